// ---- hw/mpsc_defs.svh ----
// constants of the program sequencer core: offsets, vectors, sizes
`ifndef MPSC_DEFS_SVH
`define MPSC_DEFS_SVH
`define MPSC_A_IND0     7'h00
`define MPSC_A_MP0      7'h01
`define MPSC_A_IND1     7'h02
`define MPSC_A_MP1      7'h03
`define MPSC_A_WREG     7'h05
`define MPSC_A_PCL      7'h06
`define MPSC_A_TAL      7'h07
`define MPSC_A_TRH      7'h08
`define MPSC_GP_LO      7'h28
`define MPSC_GP_N       88
`define MPSC_PC_RST     12'h000
`define MPSC_VEC_EXT    12'h004
`define MPSC_VEC_TMR    12'h008
`define MPSC_VEC_ADC    12'h00c
`define MPSC_MASK_L     12'hfff
`define MPSC_MASK_S     12'h7ff
`define MPSC_PAGE_LAST  4'hf
`define MPSC_STK_N      6
`define MPSC_STK_FULL   3'h6
`define MPSC_PH_RST     4'h1
`endif

// ---- hw/mpsc_pkg.sv ----
// types shared by the program sequencer core and its neighbours
package mpsc_pkg;
    typedef enum logic [3:0] {
        mpsc_op_none,
        mpsc_op_jump,
        mpsc_op_call,
        mpsc_op_sub_return,
        mpsc_op_isr_return,
        mpsc_op_skip,
        mpsc_op_table_read_current_page,
        mpsc_op_table_read_last_page,
        mpsc_op_read,
        mpsc_op_write,
        mpsc_op_bit_set,
        mpsc_op_bit_clear
    } mpsc_op_e;

    // decoded form of the instruction in execute
    typedef struct packed {
        mpsc_op_e   op;
        logic [11:0] target;
        logic [6:0]  addr;
        logic [2:0]  bit_idx;
        logic [7:0]  wdata;
        logic        skip;
    } mpsc_cmd_s;

    // access to a peripheral register held outside
    typedef struct packed {
        logic       wr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } mpsc_ext_s;
endpackage

// ---- hw/mpsc_core.sv ----
// program sequencer core: phases, fetch/execute pipe, pc, stack, data map
//
// Contract
// - system clock splits into four phases; one instruction cycle is four clocks.
// - fetch overlaps execute; pc-changing instructions add a dummy cycle.
// - pc is 11 bits small variant, 12 bits (4096 words) large.
// - pc increments by one after every instruction fetch.
// - taken skip discards the fetched instruction; pc becomes old plus two.
// - reset clears pc so execution starts at address zero.
// - acknowledged interrupt loads vector 004, 008 or 00C if stack not full.
// - write to pc low byte at 06 replaces bits 7..0 only.
// - jump and call load pc from instruction; return loads stack top.
// - table address is table pointer low, upper from pc or all ones.
// - table read puts low byte in data memory, high bits at 08.
// - table high byte register is read only; only table reads update it.
// - every table read takes two instruction cycles.
// - six-entry hidden stack; calls and interrupts push, both returns pop.
// - reset leaves the stack empty.
// - with stack full an interrupt waits until a return pops an entry.
// - call on a full stack drops the oldest entry, keeps six newest.
// - unimplemented data locations below 28 read as zero.
// - general purpose memory spans 28 to 7F; all memory fully operable.
// - any data bit may be set or cleared by bit instructions; the code leaves 08 and pointer bit 7 unchanged.
// - access to 00 or 02 goes to location held in pointer 0 or 1.
// - pointer aimed at 00 or 02 reads zero and writes nothing.
// - both memory pointers are seven bits wide.
// - working register sits at 05; memory moves pass through it.
`timescale 1ns/1ps
`include "mpsc_defs.svh"

module mpsc_core
    import mpsc_pkg::*;
#(
    parameter bit LARGE_VARIANT = 1'b1
) (
    // clock and reset
    input  wire logic       clk_sys_i,
    input  wire logic       rst_b_i,
    // program memory
    output logic [11:0]     pmem_addr_o,
    input  wire logic [14:0] pmem_data_i,
    // instruction decoder
    output logic [14:0]     instr_o,
    output logic            exec_valid_o,
    input  wire mpsc_cmd_s  cmd_i,
    output logic [3:0]      phase_o,
    output logic [7:0]      data_rd_o,
    // peripheral registers
    output mpsc_ext_s       ext_o,
    input  wire logic [7:0] ext_rdata_i,
    // interrupt control
    input  wire logic [2:0] int_req_i,
    output logic [2:0]      int_ack_o,
    output logic            isr_return_o,
    output logic            stack_full_o
);

    localparam logic [11:0] PC_MASK = LARGE_VARIANT ? `MPSC_MASK_L : `MPSC_MASK_S;
    logic [3:0]  phase_reg;
    logic [11:0] pc_reg;
    logic [11:0] pc_next;
    logic [11:0] paddr_reg;
    logic [14:0] instr_reg;
    logic        valid_reg;
    logic        tbl_busy_reg;
    logic [6:0]  tbl_dst_reg;
    logic [6:0]  mp0_reg;
    logic [6:0]  mp1_reg;
    logic [7:0]  wreg_reg;
    logic [7:0]  tal_reg;
    logic [7:0]  trh_reg;
    logic [7:0]  rd_reg;
    logic [6:0]  eff_reg;
    logic [7:0]  gp_mem [0:`MPSC_GP_N-1];
    logic [11:0] stk_reg [0:`MPSC_STK_N-1];
    logic [2:0]  depth_reg;
    logic        full_reg;
    logic [2:0]  ack_reg;
    logic        iret_reg;
    mpsc_ext_s   ext_reg;
    logic        ph0;
    logic        ph1;
    logic        ph3;
    logic        exec;
    logic        is_jmp;
    logic        is_call;
    logic        is_ret;
    logic        is_iret;
    logic        is_trd;
    logic        is_trl;
    logic        is_wr;
    logic        skip_hit;
    logic        int_go;
    logic        push;
    logic        pop;
    logic        discard;
    logic        pcl_wr;
    logic        wr_en;
    logic [6:0]  eff_addr;
    logic [6:0]  wr_addr;
    logic [7:0]  wr_data;
    logic [7:0]  bit_mask;
    logic [7:0]  rd_mux;
    logic [11:0] pc_inc;
    logic [11:0] tbl_addr;
    logic [11:0] vec;
    logic [6:0]  gp_rd_idx;
    logic [6:0]  gp_wr_idx;
    logic        eff_gp;
    logic        wr_gp;
    logic        data_hi;
    // one-hot phase ring
    assign ph0 = phase_reg[0];
    assign ph1 = phase_reg[1];
    assign ph3 = phase_reg[3];
    // a table read freezes the pipe for one cycle
    assign exec     = valid_reg && !tbl_busy_reg;
    assign is_jmp   = exec && (cmd_i.op == mpsc_op_jump || cmd_i.op == mpsc_op_call);
    assign is_call  = exec && cmd_i.op == mpsc_op_call;
    assign is_iret  = exec && cmd_i.op == mpsc_op_isr_return;
    assign is_ret   = exec && (cmd_i.op == mpsc_op_sub_return || is_iret);
    assign is_trl   = exec && cmd_i.op == mpsc_op_table_read_last_page;
    assign is_trd   = is_trl || (exec && cmd_i.op == mpsc_op_table_read_current_page);
    assign is_wr    = exec && (cmd_i.op == mpsc_op_write || cmd_i.op == mpsc_op_bit_set
                               || cmd_i.op == mpsc_op_bit_clear);
    assign skip_hit = exec && cmd_i.op == mpsc_op_skip && cmd_i.skip;
    // indirect access through the two pointers
    assign eff_addr = (cmd_i.addr == `MPSC_A_IND0) ? mp0_reg :
                      (cmd_i.addr == `MPSC_A_IND1) ? mp1_reg : cmd_i.addr;
    function automatic logic is_self(input logic [6:0] a);
        return a == `MPSC_A_IND0 || a == `MPSC_A_IND1;
    endfunction
    // peripheral registers living in the neighbouring blocks
    function automatic logic is_ext(input logic [6:0] a);
        return a == 7'h0a || a == 7'h0b || a == 7'h0d || a == 7'h0e
            || (a >= 7'h12 && a <= 7'h1a) || (a >= 7'h20 && a <= 7'h23);
    endfunction
    assign eff_gp    = eff_reg >= `MPSC_GP_LO;
    assign gp_rd_idx = eff_reg - `MPSC_GP_LO;
    assign wr_addr   = tbl_busy_reg ? tbl_dst_reg : eff_reg;
    assign wr_gp     = wr_addr >= `MPSC_GP_LO;
    assign gp_wr_idx = wr_addr - `MPSC_GP_LO;

    always_comb begin
        if (eff_gp) begin
            rd_mux = gp_mem[gp_rd_idx];
        end else if (is_ext(eff_reg)) begin
            rd_mux = ext_rdata_i;
        end else begin
            unique case (eff_reg)
                `MPSC_A_MP0:  rd_mux = {1'b0, mp0_reg};
                `MPSC_A_MP1:  rd_mux = {1'b0, mp1_reg};
                `MPSC_A_WREG: rd_mux = wreg_reg;
                `MPSC_A_PCL:  rd_mux = pc_reg[7:0];
                `MPSC_A_TAL:  rd_mux = tal_reg;
                `MPSC_A_TRH:  rd_mux = trh_reg;
                // holes and the indirect slots themselves read zero
                default:      rd_mux = 8'h00;
            endcase
        end
    end
    assign bit_mask = 8'h01 << cmd_i.bit_idx;
    assign wr_data  = tbl_busy_reg ? pmem_data_i[7:0] :
                      (cmd_i.op == mpsc_op_bit_set)   ? (rd_reg | bit_mask) :
                      (cmd_i.op == mpsc_op_bit_clear) ? (rd_reg & ~bit_mask) :
                      cmd_i.wdata;
    assign wr_en    = ph3 && (tbl_busy_reg || is_wr) && !is_self(wr_addr);
    assign pcl_wr   = wr_en && wr_addr == `MPSC_A_PCL;
    assign data_hi  = LARGE_VARIANT ? pmem_data_i[14] : 1'b0;
    // interrupt priority: external, timer, converter
    assign vec = int_req_i[0] ? `MPSC_VEC_EXT :
                 int_req_i[1] ? `MPSC_VEC_TMR : `MPSC_VEC_ADC;
    // held off while the stack is full or another transfer is under way
    assign int_go = ph3 && |int_req_i && !full_reg && !tbl_busy_reg
                    && !(is_jmp || is_ret || skip_hit || pcl_wr || is_trd);
    assign push    = ph3 && (is_call || int_go);
    assign pop     = ph3 && is_ret;
    assign discard = ph3 && (is_jmp || is_ret || skip_hit || pcl_wr || int_go);
    assign pc_inc   = (pc_reg + 12'h001) & PC_MASK;
    assign tbl_addr = {is_trl ? `MPSC_PAGE_LAST : pc_reg[11:8], tal_reg} & PC_MASK;
    always_comb begin
        if (pcl_wr) begin
            pc_next = {pc_reg[11:8], wr_data} & PC_MASK;
        end else if (tbl_busy_reg) begin
            pc_next = pc_reg;
        end else if (is_jmp) begin
            pc_next = cmd_i.target & PC_MASK;
        end else if (is_ret) begin
            pc_next = stk_reg[0];
        end else if (int_go) begin
            pc_next = vec;
        end else begin
            // a taken skip also lands here: the fetched word is dropped
            pc_next = pc_inc;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            phase_reg <= `MPSC_PH_RST;
        end else begin
            phase_reg <= {phase_reg[2:0], phase_reg[3]};
        end
    end

    // fetch at the last phase, next address out at the same edge
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pc_reg       <= `MPSC_PC_RST;
            paddr_reg    <= `MPSC_PC_RST;
            instr_reg    <= 15'h0000;
            valid_reg    <= 1'b0;
            tbl_busy_reg <= 1'b0;
            tbl_dst_reg  <= 7'h00;
        end else if (ph3) begin
            pc_reg       <= pc_next;
            paddr_reg    <= is_trd ? tbl_addr : pc_next;
            tbl_busy_reg <= is_trd;
            if (is_trd) begin
                tbl_dst_reg <= eff_reg;
            end
            if (!tbl_busy_reg) begin
                instr_reg <= pmem_data_i;
                valid_reg <= !discard;
            end else if (discard) begin
                valid_reg <= 1'b0;
            end
        end
    end

    // operand address at phase 0, operand read at phase 1
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            eff_reg <= 7'h00;
            rd_reg  <= 8'h00;
        end else begin
            if (ph0 && exec) begin
                eff_reg <= eff_addr;
            end
            if (ph1) begin
                rd_reg <= rd_mux;
            end
        end
    end

    // writes land at phase 3
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            mp0_reg  <= 7'h00;
            mp1_reg  <= 7'h00;
            wreg_reg <= 8'h00;
            tal_reg  <= 8'h00;
        end else if (wr_en) begin
            if (wr_addr == `MPSC_A_MP0) begin
                mp0_reg <= wr_data[6:0];
            end
            if (wr_addr == `MPSC_A_MP1) begin
                mp1_reg <= wr_data[6:0];
            end
            if (wr_addr == `MPSC_A_WREG) begin
                wreg_reg <= wr_data;
            end
            if (wr_addr == `MPSC_A_TAL) begin
                tal_reg <= wr_data;
            end
        end
    end

    // storage array left without reset on purpose
    always_ff @(posedge clk_sys_i) begin
        if (wr_en && wr_gp) begin
            gp_mem[gp_wr_idx] <= wr_data;
        end
    end

    // software writes never reach this byte
    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            trh_reg <= 8'h00;
        end else if (ph3 && tbl_busy_reg) begin
            trh_reg <= {1'b0, data_hi, pmem_data_i[13:8]};
        end
    end

    // shifting stack: a push on a full stack drops the oldest entry
    for (genvar i = 0; i < `MPSC_STK_N; i++) begin : g_stk
        logic [11:0] push_src;
        logic [11:0] pop_src;
        if (i == 0) begin : g_first
            assign push_src = pc_reg;
        end else begin : g_rest
            assign push_src = stk_reg[i-1];
        end
        if (i == `MPSC_STK_N - 1) begin : g_last
            assign pop_src = 12'h000;
        end else begin : g_mid
            assign pop_src = stk_reg[i+1];
        end
        always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
            if (!rst_b_i) begin
                stk_reg[i] <= 12'h000;
            end else if (push) begin
                stk_reg[i] <= push_src;
            end else if (pop) begin
                stk_reg[i] <= pop_src;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            depth_reg <= 3'h0;
            full_reg  <= 1'b0;
        end else if (push && !full_reg) begin
            depth_reg <= depth_reg + 3'h1;
            full_reg  <= depth_reg == `MPSC_STK_FULL - 3'h1;
        end else if (pop && depth_reg != 3'h0) begin
            depth_reg <= depth_reg - 3'h1;
            full_reg  <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ack_reg  <= 3'h0;
            iret_reg <= 1'b0;
            ext_reg  <= '0;
        end else begin
            ack_reg  <= int_go ? (int_req_i & ~(int_req_i - 3'h1)) : 3'h0;
            iret_reg <= ph3 && is_iret;
            ext_reg.wr <= wr_en && is_ext(wr_addr);
            if (ph0 && exec) begin
                ext_reg.addr <= eff_addr;
            end
            if (ph3) begin
                ext_reg.addr  <= wr_addr;
                ext_reg.wdata <= wr_data;
            end
        end
    end

    assign pmem_addr_o  = paddr_reg;
    assign instr_o      = instr_reg;
    assign exec_valid_o = valid_reg;
    assign phase_o      = phase_reg;
    assign data_rd_o    = rd_reg;
    assign ext_o        = ext_reg;
    assign int_ack_o    = ack_reg;
    assign isr_return_o = iret_reg;
    assign stack_full_o = full_reg;

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);

    sequence s_phase_walk;
        phase_reg[1] ##1 phase_reg[2] ##1 phase_reg[3] ##1 phase_reg[0];
    endsequence
    sequence s_dummy_cycle;
        !valid_reg [*4];
    endsequence
    sequence s_table_hold;
        tbl_busy_reg [*4] ##1 !tbl_busy_reg;
    endsequence

    a_phase_ring_walk: assert property (ph0 |=> s_phase_walk)
        else $error("phase ring out of order");
    a_transfer_dummy: assert property (ph3 && is_jmp |=> s_dummy_cycle)
        else $error("no dummy cycle after jump");
    a_pc_fetch_inc: assert property (ph3 && !tbl_busy_reg && !discard |=>
        pc_reg == ((12'($past(pc_reg)) + 12'h001) & PC_MASK))
        else $error("pc not incremented after fetch");
    a_skip_plus_two: assert property (ph3 && skip_hit |=>
        pc_reg == ((12'($past(pc_reg)) + 12'h001) & PC_MASK) && !valid_reg)
        else $error("skip did not drop next instruction");
    a_jump_load: assert property (ph3 && is_jmp && !pcl_wr |=>
        pc_reg == ($past(cmd_i.target) & PC_MASK))
        else $error("jump target not loaded");
    a_int_vector_ext: assert property (int_go && int_req_i[0] |=>
        pc_reg == `MPSC_VEC_EXT && int_ack_o == 3'h1)
        else $error("external vector not taken");
    a_int_full_hold: assert property (depth_reg == `MPSC_STK_FULL |-> !int_go)
        else $error("interrupt taken on full stack");
    a_pcl_keep_upper: assert property (pcl_wr |=>
        pc_reg[11:8] == $past(pc_reg[11:8]) && pc_reg[7:0] == $past(wr_data))
        else $error("pc low write disturbed upper bits");
    a_trh_read_only: assert property (!(ph3 && tbl_busy_reg) |=> $stable(trh_reg))
        else $error("table high byte changed outside a table read");
    a_table_two_cyc: assert property (ph3 && is_trd |=> s_table_hold)
        else $error("table read not two cycles");
    a_stack_depth: assert property (depth_reg <= `MPSC_STK_FULL)
        else $error("stack depth past six");
    a_ind_self_zero: assert property (ph1 && is_self(eff_reg) |=> rd_reg == 8'h00)
        else $error("self indirect read not zero");

endmodule

// ---- tb/mpsc_mem_model.sv ----
// program memory, decoder and peripheral model facing the sequencer core
`timescale 1ns/1ps
module mpsc_mem_model
    import mpsc_pkg::*;
(
    // program memory side
    input  wire logic [11:0] pmem_addr_i,
    output logic [14:0]      pmem_data_o,
    // decode side
    input  wire logic [14:0] instr_i,
    input  wire logic        exec_valid_i,
    output mpsc_cmd_s        cmd_o,
    // peripheral side
    input  wire mpsc_ext_s   ext_i,
    output logic [7:0]       ext_rdata_o
);
    // filled by the bench before reset is released
    logic [14:0] rom     [0:4095];
    mpsc_cmd_s   cmd_tab [0:4095];

    // combinational rom, settled long before the phase-3 edge
    assign pmem_data_o = rom[pmem_addr_i];
    // dummy cycles decode as no operation, so a stale word never acts
    assign cmd_o       = exec_valid_i ? cmd_tab[instr_i[11:0]] : '0;
    // a peripheral answers with its own address, marked by bit 7
    assign ext_rdata_o = {1'b1, ext_i.addr};
endmodule

// ---- tb/test_mcu_program_sequencer_core.sv ----
// self-checking bench: assembles a program into the model and checks results
`timescale 1ns/1ps
module test_mcu_program_sequencer_core
    import mpsc_pkg::*;
;
    // clock and reset
    logic        clk_sys_i;
    logic        rst_b_i;
    // core signals
    logic [11:0] pmem_addr;
    logic [14:0] pmem_data;
    logic [14:0] instr;
    logic        exec_valid;
    mpsc_cmd_s   cmd;
    logic [3:0]  phase;
    logic [7:0]  data_rd;
    mpsc_ext_s   ext;
    logic [7:0]  ext_rdata;
    logic [2:0]  int_req;
    logic [2:0]  int_ack;
    logic        isr_ret;
    logic        stack_full;
    // bench state
    int          n_errors;
    int          checked;
    int          n_rd;
    int          n_rd_seen;
    logic [11:0] pw;
    logic [3:0]  ph_prev;
    logic        tbl_stall;
    logic [7:0]  exp_tab [0:4095];

    mpsc_core #(.LARGE_VARIANT(1'b1)) u_dut (
        .clk_sys_i    (clk_sys_i),
        .rst_b_i      (rst_b_i),
        .pmem_addr_o  (pmem_addr),
        .pmem_data_i  (pmem_data),
        .instr_o      (instr),
        .exec_valid_o (exec_valid),
        .cmd_i        (cmd),
        .phase_o      (phase),
        .data_rd_o    (data_rd),
        .ext_o        (ext),
        .ext_rdata_i  (ext_rdata),
        .int_req_i    (int_req),
        .int_ack_o    (int_ack),
        .isr_return_o (isr_ret),
        .stack_full_o (stack_full)
    );

    mpsc_mem_model u_mem (
        .pmem_addr_i  (pmem_addr),
        .pmem_data_o  (pmem_data),
        .instr_i      (instr),
        .exec_valid_i (exec_valid),
        .cmd_o        (cmd),
        .ext_i        (ext),
        .ext_rdata_o  (ext_rdata)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #4 clk_sys_i = ~clk_sys_i;
    end

    task automatic give_verdict();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // 0: stack full, 1: any acknowledge, 2: fetch reached the idle page
    task automatic wait_cond(input int w, input int lim);
        int i;
        for (i = 0; i < lim; i++) begin
            @(posedge clk_sys_i);
            #1;
            if ((w == 0 && stack_full === 1'b1) || (w == 1 && int_ack !== 3'b000)
                || (w == 2 && pmem_addr[11:8] === 4'h3)) begin
                break;
            end
        end
        if (i == lim) begin
            n_errors++;
            give_verdict();
        end
    endtask

    // assembles one instruction at pw; a skip is taken when d[0] is set
    task automatic emit(input mpsc_op_e op, input logic [11:0] tg, input logic [6:0] a,
                        input logic [2:0] b, input logic [7:0] d, input logic [7:0] e);
        u_mem.cmd_tab[pw] = '{op, tg, a, b, d, op == mpsc_op_skip && d[0]};
        u_mem.rom[pw] = {3'h0, pw};
        exp_tab[pw] = e;
        if (op == mpsc_op_read) n_rd++;
        pw++;
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        emit(mpsc_op_write, 12'h000, a, 3'h0, d, 8'h00);
    endtask

    task automatic rd(input logic [6:0] a, input logic [7:0] e);
        emit(mpsc_op_read, 12'h000, a, 3'h0, 8'h00, e);
    endtask

    task automatic br(input mpsc_op_e op, input logic [11:0] tg);
        emit(op, tg, 7'h00, 3'h0, 8'h00, 8'h00);
    endtask

    // sampled before the edge lands, so registered outputs are settled
    always @(posedge clk_sys_i) begin
        if (rst_b_i === 1'b1 && ph_prev !== 4'h0) begin
            chk({12'h000, phase}, {12'h000, ph_prev[2:0], ph_prev[3]});
        end
        ph_prev = rst_b_i ? phase : 4'h0;
        // the word held through a table-read stall stays valid but has not run yet
        if (rst_b_i !== 1'b1) begin
            tbl_stall = 1'b0;
        end else if (phase === 4'b1000 && tbl_stall === 1'b1) begin
            tbl_stall = 1'b0;
        end else if (phase === 4'b1000 && exec_valid === 1'b1) begin
            if (cmd.op === mpsc_op_read) begin
                n_rd_seen++;
                chk({8'h00, data_rd}, {8'h00, exp_tab[instr[11:0]]});
            end
            tbl_stall = cmd.op === mpsc_op_table_read_current_page
                        || cmd.op === mpsc_op_table_read_last_page;
        end
    end

    initial begin
        n_errors = 0;
        checked = 0;
        n_rd = 0;
        n_rd_seen = 0;
        ph_prev = 4'h0;
        rst_b_i = 1'b0;
        int_req = 3'b000;
        for (int i = 0; i < 4096; i++) begin
            u_mem.rom[i] = 15'h0000;
            u_mem.cmd_tab[i] = '0;
            exp_tab[i] = 8'h00;
        end
        pw = 12'h000;
        br(mpsc_op_jump, 12'h110);
        for (int v = 1; v < 4; v++) begin
            pw = 12'(4 * v);
            rd(7'h06, 8'(4 * v + 1));
            br(mpsc_op_isr_return, 12'h000);
        end
        pw = 12'h180;
        wr(7'h2d, 8'h77);
        br(mpsc_op_sub_return, 12'h000);
        pw = 12'h110;
        wr(7'h05, 8'h5a);
        rd(7'h05, 8'h5a);
        wr(7'h01, 8'h30);
        wr(7'h00, 8'hc3);
        rd(7'h30, 8'hc3);
        rd(7'h00, 8'hc3);
        wr(7'h03, 8'h82);
        rd(7'h03, 8'h02);
        wr(7'h02, 8'h11);
        rd(7'h02, 8'h00);
        rd(7'h04, 8'h00);
        rd(7'h0a, 8'h8a);
        wr(7'h07, 8'h40);
        emit(mpsc_op_table_read_current_page, 12'h000, 7'h29, 3'h0, 8'h00, 8'h00);
        rd(7'h29, 8'h3c);
        rd(7'h08, 8'h5a);
        wr(7'h08, 8'hff);
        rd(7'h08, 8'h5a);
        wr(7'h07, 8'h41);
        emit(mpsc_op_table_read_last_page, 12'h000, 7'h2a, 3'h0, 8'h00, 8'h00);
        rd(7'h2a, 8'h34);
        rd(7'h08, 8'h12);
        wr(7'h2b, 8'h00);
        emit(mpsc_op_bit_set, 12'h000, 7'h2b, 3'h7, 8'h00, 8'h00);
        emit(mpsc_op_bit_set, 12'h000, 7'h2b, 3'h0, 8'h00, 8'h00);
        emit(mpsc_op_bit_clear, 12'h000, 7'h2b, 3'h7, 8'h00, 8'h00);
        rd(7'h2b, 8'h01);
        wr(7'h2c, 8'h00);
        emit(mpsc_op_skip, 12'h000, 7'h00, 3'h0, 8'h01, 8'h00);
        wr(7'h2c, 8'hee);
        rd(7'h2c, 8'h00);
        emit(mpsc_op_skip, 12'h000, 7'h00, 3'h0, 8'h00, 8'h00);
        wr(7'h2c, 8'h55);
        br(mpsc_op_call, 12'h180);
        rd(7'h2d, 8'h77);
        wr(7'h06, 8'h60);
        wr(7'h2c, 8'hee);
        pw = 12'h160;
        rd(7'h2c, 8'h55);
        br(mpsc_op_call, 12'h200);
        // seven nested calls; the one from 0x161 must be dropped
        for (int k = 0; k < 6; k++) begin
            pw = 12'h200 + 12'(16 * k);
            br(mpsc_op_call, pw + 12'h010);
            rd(7'h06, 8'(16 * k + 2));
            br(k == 0 ? mpsc_op_jump : mpsc_op_sub_return, 12'h300);
        end
        pw = 12'h260;
        br(mpsc_op_sub_return, 12'h000);
        pw = 12'h300;
        br(mpsc_op_none, 12'h000);
        br(mpsc_op_jump, 12'h300);
        u_mem.rom[12'h140] = 15'h5a3c;
        u_mem.rom[12'hf41] = 15'h1234;
        repeat (16) @(posedge clk_sys_i);
        chk({4'h0, pmem_addr}, 16'h0000);
        chk({15'h0000, stack_full}, 16'h0000);
        #1;
        rst_b_i = 1'b1;
        wait_cond(0, 3000);
        int_req = 3'b001;
        for (int i = 0; i < 400 && stack_full === 1'b1; i++) begin
            chk({13'h0000, int_ack}, 16'h0000);
            @(posedge clk_sys_i);
            #1;
        end
        if (stack_full !== 1'b0) begin
            n_errors++;
            give_verdict();
        end
        wait_cond(1, 64);
        chk({13'h0000, int_ack}, 16'h0001);
        int_req = 3'b000;
        wait_cond(2, 3000);
        chk({15'h0000, stack_full}, 16'h0000);
        for (int k = 1; k < 3; k++) begin
            int_req = 3'(1 << k);
            wait_cond(1, 64);
            chk({13'h0000, int_ack}, 16'(1 << k));
            int_req = 3'b000;
            repeat (40) @(posedge clk_sys_i);
            #1;
        end
        chk(16'(n_rd_seen), 16'(n_rd));
        give_verdict();
    end
endmodule
